// file: bench/qdb_mem_model.sv
/*
  qdb_mem_model: behavioural burst-of-4 DDR static memory, x36.
  Assumes the controller makes the input clock pair and drives the pins.
*/
`timescale 1ns/1ps
`default_nettype none
module qdb_mem_model (
  input wire logic in_clk_p,
  input wire logic in_clk_n,
  input wire logic [18:0] mem_addr_in,
  input wire logic write_sel_n,
  input wire logic read_sel_n,
  input wire logic [3:0] byte_write_en_n,
  input wire logic [35:0] write_input_bus,
  input wire logic dll_bypass_n,
  output wire logic echo_strobe_p,
  output wire logic echo_strobe_n,
  output var logic out_valid_flag,
  output var logic [35:0] read_output_bus
);
  logic [35:0] mem [int];
  logic [35:0] w;
  logic [18:0] wa, ra;
  int wn = 0;
  int rn = 0;
  int lat = 4;
  // echo strobes run freely, edges aligned with read data
  assign #1 echo_strobe_p = in_clk_p;
  assign #1 echo_strobe_n = in_clk_n;
  initial out_valid_flag = 1'b0;
  initial read_output_bus = 36'h0;
  // ----------------------------------------------------------------
  // edge index counts every rise of either input clock
  // ----------------------------------------------------------------
  // one always block per edge kind passes its edge to on_edge: both clocks flip in one step, so the level of the
  // other clock cannot be trusted to tell which edge woke the model
  task automatic on_edge(input logic rise_p);
    if (wn > 0) begin
      wn++;
      if (wn >= 3) begin
        w = mem[{wa, 2'(wn - 3)}];
        for (int j = 0; j < 4; j++) begin
          if (!byte_write_en_n[j]) w[9*j+:9] = write_input_bus[9*j+:9];
        end
        mem[{wa, 2'(wn - 3)}] = w;
        if (wn == 6) wn = 0;
      end
    end
    if (rn > 0) begin
      rn++;
      if (rn > lat && rn <= lat + 4) begin
        read_output_bus <= #1 mem[{ra, 2'(rn - lat - 1)}];
        out_valid_flag <= #1 1'b1;
      end else if (rn > lat + 4) begin
        // released bus shows no stale data
        read_output_bus <= #1 ~read_output_bus;
        out_valid_flag <= #1 1'b0;
        rn = 0;
      end
    end
    // no select means no operation and the address is ignored
    if (rise_p && !write_sel_n) begin
      wa = mem_addr_in;
      wn = 1;
    end
    if (rise_p && !read_sel_n) begin
      ra = mem_addr_in;
      rn = 1;
      lat = dll_bypass_n ? 4 : 2;
    end
  endtask
  always @(posedge in_clk_p) on_edge(1'b1);
  always @(posedge in_clk_n) on_edge(1'b0);
endmodule
`default_nettype wire

// file: bench/qdb_sram_ctrl_chk.sv
/*
  qdb_sram_ctrl_chk: timing checks on the memory-side pins.
  Assumes it is bound into qdb_sram_ctrl and sees its ports.
*/
`timescale 1ns/1ps
`default_nettype none
module qdb_sram_ctrl_chk #(
  parameter int DATA_W = 36,
  parameter int ADDR_W = 19,
  parameter int BW_W = 4
) (
  input wire logic sys_clk,
  input wire logic sys_rst,
  input wire logic in_clk_p,
  input wire logic in_clk_n,
  input wire logic [ADDR_W-1:0] mem_addr_in,
  input wire logic write_sel_n,
  input wire logic read_sel_n,
  input wire logic [BW_W-1:0] byte_write_en_n,
  input wire logic [DATA_W-1:0] write_input_bus,
  input wire logic dll_bypass_n
);
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (sys_rst);
  a_clk_compl: assert property (in_clk_n == !in_clk_p)
    else $error("input clock pair not complementary");
  a_clk_period: assert property ($rose(in_clk_p) |-> ##4 $rose(in_clk_p))
    else $error("input clock period wrong");
  a_sel_at_rise: assert property (
    ($fell(write_sel_n) || $fell(read_sel_n)) |-> ##1 $rose(in_clk_p))
    else $error("select not set up before clock rise");
  a_wsel_len: assert property ($fell(write_sel_n) |-> (!write_sel_n) [*4] ##1 write_sel_n)
    else $error("write select length wrong");
  a_rsel_len: assert property ($fell(read_sel_n) |-> (!read_sel_n) [*4] ##1 read_sel_n)
    else $error("read select length wrong");
  a_addr_hold: assert property (
    ($fell(write_sel_n) || $fell(read_sel_n)) |=> $stable(mem_addr_in) [*3])
    else $error("address moved during command");
  a_sel_apart: assert property (write_sel_n || read_sel_n)
    else $error("read and write selects together");
  a_data_mid: assert property (
    ($changed(write_input_bus) || $changed(byte_write_en_n)) |-> $stable(in_clk_p))
    else $error("write data changed at a clock edge");
  a_wr_first: assert property ($fell(write_sel_n) |-> ##1 (&byte_write_en_n) [*3])
    else $error("write beat too early");
  a_wr_end: assert property ($fell(write_sel_n) |-> ##12 (&byte_write_en_n))
    else $error("write burst too long");
  cover property ($fell(write_sel_n));
  cover property ($fell(read_sel_n) && !dll_bypass_n);
  cover property ($fell(write_sel_n) ##[1:8] $fell(read_sel_n));
endmodule
bind qdb_sram_ctrl qdb_sram_ctrl_chk #(.DATA_W(DATA_W), .ADDR_W(ADDR_W), .BW_W(BW_W)) u_chk (.*);
`default_nettype wire

// file: bench/testbench.sv
/*
  testbench: random bursts through the register port, read back via the model.
  Assumes the x36 organisation and the designer's register map.
*/
`timescale 1ns/1ps
`default_nettype none
module testbench;
  logic sys_clk = 1'b0;
  logic sys_rst = 1'b1;
  qdb_pkg::qdb_bus_s bus_req = '0;
  logic [31:0] bus_rdata, rv;
  logic in_clk_p, in_clk_n, write_sel_n, read_sel_n, dll_bypass_n, out_valid_flag;
  logic [18:0] mem_addr_in, adr;
  logic [18:0] padr = '0;
  logic [3:0] byte_write_en_n;
  logic [15:0] msk;
  logic [35:0] write_input_bus, read_output_bus;
  logic [35:0] d [4];
  logic [35:0] exp_m [4];
  logic [35:0] pexp [4];
  wire echo_strobe_p, echo_strobe_n;
  logic have = 1'b0;
  logic [31:0] seed = 32'hc70fa2fa;
  logic [7:0] ofs [4] = '{qdb_pkg::OFS_CTRL, qdb_pkg::OFS_STATUS, qdb_pkg::OFS_BWEN, 8'h80};
  logic [31:0] rst_v [4] = '{32'h1, 32'h0, 32'hffff, 32'h0};
  int n_mismatch = 0;
  int num_checks = 0;
  qdb_sram_ctrl dut (.*);
  qdb_mem_model mem (.*);
  initial begin
    forever #10 sys_clk = ~sys_clk;
  end
  function automatic logic [31:0] rnd();
    repeat (32) seed = {seed[30:0], ^(seed & 32'h80200003)};
    return seed;
  endfunction
  function automatic logic [35:0] merge(input logic [35:0] o, n, input logic [3:0] m);
    for (int j = 0; j < 4; j++) if (m[j]) o[9*j+:9] = n[9*j+:9];
    return o;
  endfunction
  task automatic stop_test();
    $display("checks %0d mismatches %0d", num_checks, n_mismatch);
    if (n_mismatch == 0 && num_checks > 0) $display("ALL CHECKS OK");
    else $display("CHECKS NOT OK");
    $finish;
  endtask
  task automatic check(input string nm, input logic [35:0] seen, exp);
    num_checks++;
    if (seen !== exp) begin
      n_mismatch++;
      $display("MISMATCH %s expected %h seen %h", nm, exp, seen);
    end
  endtask
  // ----------------------------------------------------------------
  // register port cycles, one idle cycle after each strobe
  // ----------------------------------------------------------------
  task automatic wr(input logic [7:0] a, input logic [31:0] v);
    bus_req <= '{a, v, 1'b1, 1'b0};
    @(posedge sys_clk);
    bus_req.wr <= 1'b0;
    @(posedge sys_clk);
  endtask
  task automatic rd(input logic [7:0] a, output logic [31:0] v);
    bus_req <= '{a, 32'h0, 1'b0, 1'b1};
    @(posedge sys_clk);
    bus_req.rd <= 1'b0;
    @(negedge sys_clk);
    v = bus_rdata;
    @(posedge sys_clk);
  endtask
  task automatic wait_idle();
    int i;
    for (i = 0; i < 100; i++) begin
      rd(qdb_pkg::OFS_STATUS, rv);
      if (rv[1:0] === 2'b00) break;
    end
    if (i == 100) begin
      n_mismatch++;
      $display("MISMATCH status expected idle seen busy");
      stop_test();
    end
  endtask
  task automatic load(input logic [15:0] m);
    wr(qdb_pkg::OFS_WADDR, 32'(adr));
    wr(qdb_pkg::OFS_BWEN, 32'(m));
    for (int b = 0; b < 4; b++) begin
      d[b] = {4'(rnd()), rnd()};
      wr(qdb_pkg::OFS_WBUF + 8'(8 * b), d[b][31:0]);
      wr(qdb_pkg::OFS_WBUF + 8'(8 * b + 4), 32'(d[b][35:32]));
    end
  endtask
  task automatic rcheck();
    logic [31:0] lo;
    check("status", 36'(rv[2:0]), 36'h4);
    for (int b = 0; b < 4; b++) begin
      rd(qdb_pkg::OFS_RBUF + 8'(8 * b), lo);
      rd(qdb_pkg::OFS_RBUF + 8'(8 * b + 4), rv);
      check("read_beat", {rv[3:0], lo}, pexp[b]);
    end
  endtask
  initial begin
    repeat (20) @(posedge sys_clk);
    check("pins_in_reset", {31'h0, in_clk_p, in_clk_n, write_sel_n, read_sel_n,
          dll_bypass_n}, 36'hf);
    sys_rst <= 1'b0;
    @(posedge sys_clk);
    for (int k = 0; k < 4; k++) begin
      rd(ofs[k], rv);
      check("reg_reset", 36'(rv), 36'(rst_v[k]));
    end
    $display("test reset done");
    for (int m = 1; m >= 0; m--) begin
      wr(qdb_pkg::OFS_CTRL, 32'(m));
      repeat (2) @(posedge sys_clk);
      check("dll_pin", 36'(dll_bypass_n), 36'(m));
      for (int it = 0; it < 3; it++) begin
        adr = 19'(rnd());
        load(16'hffff);
        exp_m = d;
        wr(qdb_pkg::OFS_RADDR, 32'(padr));
        // write and read launched together take turns on the address bus
        wr(qdb_pkg::OFS_CTRL, 32'(m) | 32'h2 | (have ? 32'h4 : 32'h0));
        wait_idle();
        if (have) rcheck();
        msk = (it == 0) ? 16'h0000 : (it == 1) ? 16'h5a3c : 16'(rnd());
        load(msk);
        wr(qdb_pkg::OFS_CTRL, 32'(m) | 32'h2);
        wait_idle();
        for (int b = 0; b < 4; b++) pexp[b] = merge(exp_m[b], d[b], msk[4*b+:4]);
        padr = adr;
        have = 1'b1;
      end
      $display("test mode %0d done", m);
    end
    wr(qdb_pkg::OFS_RADDR, 32'(padr));
    wr(qdb_pkg::OFS_CTRL, 32'h4);
    wait_idle();
    rcheck();
    $display("test final read done");
    stop_test();
  end
endmodule
`default_nettype wire

// file: logic/qdb_pkg.sv
/*
  qdb_pkg: constants and carrier types shared by the burst-of-4 DDR static memory
  controller. Assumes the controller runs on one 50 MHz clock and makes the memory's
  input clock pair by dividing it by four.
*/
package qdb_pkg;
  // ----------------------------------------------------------------
  // organisation
  // ----------------------------------------------------------------
  localparam int DATA_W_X36 = 36;
  localparam int ADDR_W_X36 = 19;
  localparam int ADDR_W_X18 = 20;
  localparam int BURST_LEN = 4;
  localparam int BYTE_W = 9;
  // ----------------------------------------------------------------
  // timing: the link clock period is four system clock cycles
  // ----------------------------------------------------------------
  localparam int SYS_CLK_NS = 20;
  localparam int LINK_CLK_NS = 80;
  localparam int LINK_DIV = LINK_CLK_NS / SYS_CLK_NS;
  localparam logic [1:0] PH_KRISE = 2'h0;
  localparam logic [1:0] PH_MID_A = 2'h1;
  localparam logic [1:0] PH_KFALL = 2'h2;
  localparam logic [1:0] PH_MID_B = 2'h3;
  // ----------------------------------------------------------------
  // register map
  // ----------------------------------------------------------------
  localparam logic [7:0] OFS_CTRL = 8'h00;
  localparam logic [7:0] OFS_STATUS = 8'h04;
  localparam logic [7:0] OFS_WADDR = 8'h08;
  localparam logic [7:0] OFS_RADDR = 8'h0c;
  localparam logic [7:0] OFS_BWEN = 8'h10;
  localparam logic [7:0] OFS_WBUF = 8'h20;
  localparam logic [7:0] OFS_RBUF = 8'h40;
  localparam int CTRL_DLL_ON = 0;
  localparam int CTRL_WR_GO = 1;
  localparam int CTRL_RD_GO = 2;
  localparam logic CTRL_DLL_ON_RST = 1'b1;
  localparam int STAT_WR_BUSY = 0;
  localparam int STAT_RD_BUSY = 1;
  localparam int STAT_RD_DONE = 2;
  localparam logic [15:0] BWEN_RST = 16'hffff;
  // ----------------------------------------------------------------
  // types
  // ----------------------------------------------------------------
  typedef enum logic [2:0] {
    W_IDLE = 3'b001,
    W_PEND = 3'b010,
    W_XFER = 3'b100
  } qdb_wr_e;
  typedef enum logic [2:0] {
    R_IDLE = 3'b001,
    R_PEND = 3'b010,
    R_WAIT = 3'b100
  } qdb_rd_e;
  typedef struct packed {
    logic [7:0] addr;
    logic [31:0] wdata;
    logic wr;
    logic rd;
  } qdb_bus_s;
endpackage

// file: logic/qdb_sram_ctrl.sv
/*
  qdb_sram_ctrl: host-side controller for a separate-I/O burst-of-4 DDR static memory.
  Software loads address, byte enables and four beats, then starts a write or a read
  through a small register port. Assumes the memory's echo strobes, valid flag and
  read bus arrive asynchronously and are sampled here; the input clock pair is made
  here at a quarter of sys_clk.
*/
// Implementation choices: the address-and-strobe port and the placing of the registers.
// How it works
// [R1] data, byte-enable, address widths follow organisation
// [R2] read and write paths run concurrently
// [R3] every transfer is exactly four beats
// [R4] device starts on rising positive strobe
// [R5] reads and writes use alternating rising edges
// [R6] address and selects valid around rising edge
// [R7] beat 1 and 3 enables on positive rise
// [R8] beat 1 and 3 data on positive rise
// [R9] beat 2 and 4 on complementary rise
// [R10] byte enables travel with each beat
// [R11] first write beat one cycle after command
// [R12] later beats alternate across both strobe phases
// [R13] a write takes two clock cycles
// [R14] read beats 1,3 after 2.0 cycles
// [R15] read beats 2,4 on complementary edges
// [R16] a read takes two cycles of data
// [R17] echo strobes mark read data edges
// [R18] write select low starts a write
// [R19] read select low starts a read
// [R20] valid flag marks good read data
// [R21] DLL bypass pin selects short latency
// [R22] no select means no operation
`timescale 1ns/1ps
`default_nettype none
module qdb_sram_ctrl #(
  parameter int DATA_W = qdb_pkg::DATA_W_X36,
  parameter int ADDR_W = (DATA_W == qdb_pkg::DATA_W_X36) ? qdb_pkg::ADDR_W_X36
                                                         : qdb_pkg::ADDR_W_X18,
  parameter int BW_W = DATA_W / qdb_pkg::BYTE_W
) (
  input wire logic sys_clk,
  input wire logic sys_rst,
  input wire qdb_pkg::qdb_bus_s bus_req,
  output logic [31:0] bus_rdata,
  output logic in_clk_p,
  output logic in_clk_n,
  output logic [ADDR_W-1:0] mem_addr_in,
  output logic write_sel_n,
  output logic read_sel_n,
  output logic [BW_W-1:0] byte_write_en_n,
  output logic [DATA_W-1:0] write_input_bus,
  output logic dll_bypass_n,
  input wire logic echo_strobe_p,
  input wire logic echo_strobe_n,
  input wire logic out_valid_flag,
  input wire logic [DATA_W-1:0] read_output_bus
);
  // ----------------------------------------------------------------
  // state
  // ----------------------------------------------------------------
  typedef struct packed {
    logic [1:0] ph;
    logic slot;
    logic k;
    logic kn;
    qdb_pkg::qdb_wr_e ws;
    logic [2:0] wh;
    qdb_pkg::qdb_rd_e rs;
    logic [1:0] rb;
    logic cap;
    logic done;
    logic dll_on;
    logic [ADDR_W-1:0] waddr;
    logic [ADDR_W-1:0] raddr;
    logic [15:0] bwen;
    logic [3:0][DATA_W-1:0] wbuf;
    logic [3:0][DATA_W-1:0] rbuf;
    logic [ADDR_W-1:0] addr_o;
    logic wsel_n;
    logic rsel_n;
    logic [BW_W-1:0] bw_n;
    logic [DATA_W-1:0] d_o;
    logic ep1;
    logic ep2;
    logic ep3;
    logic en1;
    logic en2;
    logic en3;
    logic vl1;
    logic vl2;
    logic [DATA_W-1:0] rq1;
    logic [DATA_W-1:0] rq2;
    logic [31:0] rdata;
  } qdb_st_s;

  qdb_st_s st_q;
  qdb_st_s st_d;

  // ----------------------------------------------------------------
  // helpers: one beat is seen by software as a low and a high word
  // ----------------------------------------------------------------
  function automatic logic [DATA_W-1:0] put_half(input logic [DATA_W-1:0] old,
                                                 input logic hi, input logic [31:0] v);
    logic [63:0] t;
    t = 64'(old);
    if (hi) begin
      t[63:32] = v;
    end else begin
      t[31:0] = v;
    end
    return t[DATA_W-1:0];
  endfunction

  function automatic logic [31:0] get_half(input logic [DATA_W-1:0] x, input logic hi);
    logic [63:0] t;
    t = 64'(x);
    return hi ? t[63:32] : t[31:0];
  endfunction

  function automatic logic [BW_W-1:0] beat_en(input logic [15:0] bw, input logic [1:0] b);
    logic [15:0] t;
    t = bw >> (4 * b);
    return t[BW_W-1:0];
  endfunction

  // the beat counter, read before it steps, runs one ahead of the beat it sends
  function automatic logic [1:0] beat_of(input logic [2:0] cnt);
    return cnt[1:0] - 2'h1;
  endfunction

  // ----------------------------------------------------------------
  // next state
  // ----------------------------------------------------------------
  logic [1:0] ph_n;
  logic tick_a;
  logic tick_b;
  logic [1:0] beat;
  logic ep_rise;
  logic en_rise;

  always_comb begin
    st_d = st_q;
    ph_n = st_q.ph + 2'h1;
    tick_a = (ph_n == qdb_pkg::PH_MID_B);
    tick_b = (ph_n == qdb_pkg::PH_MID_A);
    beat = beat_of(st_q.wh);
    ep_rise = st_q.ep2 & ~st_q.ep3;
    en_rise = st_q.en2 & ~st_q.en3;

    // link clock pair: high in the first half, so rising edge at phase 0
    st_d.ph = ph_n;
    st_d.k = (ph_n == qdb_pkg::PH_KRISE) || (ph_n == qdb_pkg::PH_MID_A);
    st_d.kn = ~st_d.k;

    // input synchronisers
    // stage three only feeds the edge detectors; stage one feeds stage two alone
    st_d.ep1 = echo_strobe_p;
    st_d.ep2 = st_q.ep1;
    st_d.ep3 = st_q.ep2;
    st_d.en1 = echo_strobe_n;
    st_d.en2 = st_q.en1;
    st_d.en3 = st_q.en2;
    st_d.vl1 = out_valid_flag;
    st_d.vl2 = st_q.vl1;
    st_d.rq1 = read_output_bus;
    st_d.rq2 = st_q.rq1;

    // ----------------------------------------------------------------
    // command slots: controls change mid-low so they straddle the rising edge
    // ----------------------------------------------------------------
    if (tick_a) begin
      // slot parity keeps writes on odd link cycles and reads on even ones
      st_d.slot = ~st_q.slot;
      st_d.wsel_n = 1'b1; // R22
      st_d.rsel_n = 1'b1; // R22
      if (st_q.ws == qdb_pkg::W_PEND && st_d.slot) begin // R5
        st_d.wsel_n = 1'b0; // R18
        st_d.addr_o = st_q.waddr; // R6
        st_d.ws = qdb_pkg::W_XFER;
        st_d.wh = 3'h0;
      end
      if (st_q.rs == qdb_pkg::R_PEND && !st_d.slot) begin // R5
        st_d.rsel_n = 1'b0; // R19
        st_d.addr_o = st_q.raddr; // R6
        st_d.rs = qdb_pkg::R_WAIT;
        st_d.rb = 2'h0;
      end
    end

    // ----------------------------------------------------------------
    // write beats: data and enables change at mid phase, sampled on either rise
    // ----------------------------------------------------------------
    if ((tick_a || tick_b) && !(tick_a && st_d.ws == qdb_pkg::W_XFER && st_q.ws != st_d.ws)) begin
      st_d.bw_n = '1;
      if (st_q.ws == qdb_pkg::W_XFER) begin
        st_d.wh = st_q.wh + 3'h1;
        // first beat goes out one link cycle after the command
        if (st_d.wh >= 3'h2) begin // R11
          st_d.d_o = st_q.wbuf[beat]; // R8 R9 R12
          st_d.bw_n = ~beat_en(st_q.bwen, beat); // R7 R9 R10
        end
        if (st_d.wh == 3'h5) begin // R3 R13
          st_d.ws = qdb_pkg::W_IDLE;
        end
      end
    end

    // ----------------------------------------------------------------
    // read capture: take the beat one cycle after the echo edge, mid-eye
    // ----------------------------------------------------------------
    // no latency count on purpose: the valid flag sets the latency, so both modes share
    // this path; a memory that never answers leaves the read busy
    st_d.cap = (ep_rise | en_rise) & st_q.vl2 & (st_q.rs == qdb_pkg::R_WAIT); // R17 R20
    if (st_q.cap && st_q.rs == qdb_pkg::R_WAIT) begin // R14 R15
      st_d.rbuf[st_q.rb] = st_q.rq2;
      st_d.rb = st_q.rb + 2'h1;
      if (st_q.rb == 2'h3) begin // R3 R16
        st_d.rs = qdb_pkg::R_IDLE;
        st_d.done = 1'b1;
      end
    end

    // ----------------------------------------------------------------
    // register port
    // ----------------------------------------------------------------
    // buffers, enables and addresses are not latched at start: software must leave
    // them alone while the matching busy bit is set
    st_d.rdata = 32'h0;
    if (bus_req.wr) begin
      if (bus_req.addr == qdb_pkg::OFS_CTRL) begin
        st_d.dll_on = bus_req.wdata[qdb_pkg::CTRL_DLL_ON]; // R21
        if (bus_req.wdata[qdb_pkg::CTRL_WR_GO] && st_q.ws == qdb_pkg::W_IDLE) begin
          st_d.ws = qdb_pkg::W_PEND;
        end
        if (bus_req.wdata[qdb_pkg::CTRL_RD_GO] && st_q.rs == qdb_pkg::R_IDLE) begin // R2
          st_d.rs = qdb_pkg::R_PEND;
          st_d.done = 1'b0;
        end
      end else if (bus_req.addr == qdb_pkg::OFS_WADDR) begin
        st_d.waddr = bus_req.wdata[ADDR_W-1:0]; // R1
      end else if (bus_req.addr == qdb_pkg::OFS_RADDR) begin
        st_d.raddr = bus_req.wdata[ADDR_W-1:0];
      end else if (bus_req.addr == qdb_pkg::OFS_BWEN) begin
        st_d.bwen = bus_req.wdata[15:0];
      end else if (bus_req.addr[7:5] == qdb_pkg::OFS_WBUF[7:5] && bus_req.addr[1:0] == 2'h0) begin
        st_d.wbuf[bus_req.addr[4:3]] = put_half(st_q.wbuf[bus_req.addr[4:3]],
                                                bus_req.addr[2], bus_req.wdata);
      end
    end
    if (bus_req.rd) begin
      if (bus_req.addr == qdb_pkg::OFS_CTRL) begin
        st_d.rdata[qdb_pkg::CTRL_DLL_ON] = st_q.dll_on;
      end else if (bus_req.addr == qdb_pkg::OFS_STATUS) begin
        st_d.rdata[qdb_pkg::STAT_WR_BUSY] = (st_q.ws != qdb_pkg::W_IDLE);
        st_d.rdata[qdb_pkg::STAT_RD_BUSY] = (st_q.rs != qdb_pkg::R_IDLE);
        st_d.rdata[qdb_pkg::STAT_RD_DONE] = st_q.done;
      end else if (bus_req.addr == qdb_pkg::OFS_WADDR) begin
        st_d.rdata = 32'(st_q.waddr);
      end else if (bus_req.addr == qdb_pkg::OFS_RADDR) begin
        st_d.rdata = 32'(st_q.raddr);
      end else if (bus_req.addr == qdb_pkg::OFS_BWEN) begin
        st_d.rdata = {16'h0, st_q.bwen};
      end else if (bus_req.addr[7:5] == qdb_pkg::OFS_WBUF[7:5] && bus_req.addr[1:0] == 2'h0) begin
        st_d.rdata = get_half(st_q.wbuf[bus_req.addr[4:3]], bus_req.addr[2]);
      end else if (bus_req.addr[7:5] == qdb_pkg::OFS_RBUF[7:5] && bus_req.addr[1:0] == 2'h0) begin
        st_d.rdata = get_half(st_q.rbuf[bus_req.addr[4:3]], bus_req.addr[2]);
      end
    end
  end

  // ----------------------------------------------------------------
  // registers
  // ----------------------------------------------------------------
  always_ff @(posedge sys_clk) begin
    if (sys_rst) begin
      st_q <= '0;
      // the pair parks with in_clk_p low, so its first rise is two edges after release
      st_q.ph <= qdb_pkg::PH_KFALL;
      st_q.kn <= 1'b1;
      st_q.ws <= qdb_pkg::W_IDLE;
      st_q.rs <= qdb_pkg::R_IDLE;
      st_q.dll_on <= qdb_pkg::CTRL_DLL_ON_RST;
      st_q.bwen <= qdb_pkg::BWEN_RST;
      st_q.wsel_n <= 1'b1;
      st_q.rsel_n <= 1'b1;
      st_q.bw_n <= '1;
    end else begin
      st_q <= st_d;
    end
  end

  // ----------------------------------------------------------------
  // outputs, all from flip-flops
  // ----------------------------------------------------------------
  assign bus_rdata = st_q.rdata;
  assign in_clk_p = st_q.k; // R4
  assign in_clk_n = st_q.kn;
  assign mem_addr_in = st_q.addr_o;
  assign write_sel_n = st_q.wsel_n;
  assign read_sel_n = st_q.rsel_n;
  assign byte_write_en_n = st_q.bw_n;
  assign write_input_bus = st_q.d_o;
  // low bypasses the device's DLL and shortens its read latency
  assign dll_bypass_n = st_q.dll_on; // R21
endmodule
`default_nettype wire
